// file: common/gsr_pkg.sv
/*
 * Constants of the gas sensor register interface: register offsets,
 * field positions, values after reset and scale figures.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package gsr_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_SOFT_RESET = 8'h00;
    localparam logic [7:0] REG_MODE = 8'h01;
    localparam logic [7:0] REG_STATUS = 8'h02;
    localparam logic [7:0] REG_CONC_LO = 8'h03;
    localparam logic [7:0] REG_CONC_HI = 8'h04;
    localparam logic [7:0] REG_PRESSURE = 8'h09;
    localparam logic [7:0] REG_ALTITUDE = 8'h0A;
    localparam logic [7:0] REG_ALARM_HI = 8'h0C;
    localparam logic [7:0] REG_ALARM_LO = 8'h0D;
    localparam logic [7:0] REG_PWM_COMP = 8'h0F;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int RESET_TRIGGER_BIT = 0;
    localparam int STATUS_BUSY_BIT = 7;
    localparam int STATUS_ALARM_BIT = 6;
    localparam int STATUS_ADDR_SEL_BIT = 1;
    localparam int STATUS_IF_SEL_BIT = 0;
    localparam int PWM_ENABLE_BIT = 0;
    localparam int COMPENSATION_ENABLE_BIT = 2;
    localparam int PWM_PROPERTY_BIT = 3;
    localparam logic [7:0] PWM_COMP_MASK = 8'h0D;
    localparam logic [7:0] MODE_MASK = 8'h07;
    // ----------------------------------------------------------------
    // Target address and mode codes
    // ----------------------------------------------------------------
    localparam logic [5:0] I2C_ADDR_UPPER = 6'h34;
    localparam logic [2:0] MODE_CONTINUOUS = 3'h6;
    // ----------------------------------------------------------------
    // Values after reset (threshold step is 10 ppm per count)
    // ----------------------------------------------------------------
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] PRESSURE_RESET = 8'h00;
    localparam logic [7:0] ALTITUDE_RESET = 8'h00;
    localparam logic [7:0] ALARM_HI_RESET = 8'h64;
    localparam logic [7:0] ALARM_LO_RESET = 8'h5A;
    localparam logic [7:0] PWM_COMP_RESET = 8'h00;
    // ----------------------------------------------------------------
    // Scale figures in ppm
    // ----------------------------------------------------------------
    localparam logic [15:0] THRESHOLD_STEP_PPM = 16'h000A;
    localparam logic [14:0] CONC_MAX_PPM = 15'h2710;
    localparam int PWM_FULL_SCALE_PPM = 5000;
endpackage : gsr_pkg

// file: core/gsr_pin_sync.sv
/*
 * Three-stage input synchroniser with agreement filter for one pin.
 * Assumes the pin is asynchronous to CLK_SYS_IN.
 */
`timescale 1ns/1ps
`default_nettype none
module gsr_pin_sync #(
    parameter logic RESET_LEVEL = 1'b1
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic pin_in,
    output var logic level_out
);
    logic ff1_r;
    logic ff2_r;
    logic ff3_r;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ff1_r <= RESET_LEVEL;
            ff2_r <= RESET_LEVEL;
            ff3_r <= RESET_LEVEL;
        end else begin
            ff1_r <= pin_in;
            ff2_r <= ff1_r;
            ff3_r <= ff2_r;
        end
    end

    // A change counts once stages two and three agree
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            level_out <= RESET_LEVEL;
        end else if (ff2_r == ff3_r) begin
            level_out <= ff3_r;
        end
    end
endmodule : gsr_pin_sync
`default_nettype wire

// file: core/gsr_top.sv
/*
 * I2C target register interface of a gas concentration sensor: target
 * state machine, register file, alarm with hysteresis and PWM output.
 * Assumes a measurement engine on CLK_SYS_IN supplying concentration
 * and busy, and SCL/SDA pins resolved by an open-drain wire outside.
 */
// What this block does
// [RULE1] Mode register write 06H selects continuous mode
// [RULE2] Supports current-address and random reads
// [RULE3] Concentration read as two bytes from 03H
// [RULE4] 15-bit concentration split over 03H and 04H
// [RULE5] Status: busy, alarm, address pin, interface pin
// [RULE6] Upper threshold at 0CH raises alarm
// [RULE7] Lower threshold at 0DH clears alarm
// [RULE8] Function register: PWM enable and property
// [RULE9] Function bit 2 enables pressure/altitude compensation
// [RULE10] Serial concentration limited to 10000 ppm
// [RULE11] PWM output saturates at 5000 ppm
// [RULE12] Default threshold hysteresis is 100 ppm
// [RULE13] Target address 110100 plus address pin, R/W
// [RULE14] Bytes shifted most significant bit first
// [RULE15] I2C active only with interface pin low
// [RULE16] Register pointer advances after each byte
// [RULE17] Writes to read-only bits acknowledged, ignored
`timescale 1ns/1ps
`default_nettype none
module gsr_top #(
    parameter int PWM_FULL_SCALE = gsr_pkg::PWM_FULL_SCALE_PPM
) (
    input wire logic CLK_SYS_IN,
    input wire logic RST_N_IN,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_N_OUT,
    input wire logic ADDRESS_SELECT_PIN_IN,
    input wire logic INTERFACE_SELECT_PIN_IN,
    input wire logic [14:0] CONC_IN,
    input wire logic CONC_VALID_IN,
    input wire logic BUSY_IN,
    output logic ALARM_OUT,
    output logic PWM_OUT,
    output logic [2:0] MODE_OUT,
    output logic COMP_EN_OUT,
    output logic [7:0] PRESSURE_OUT,
    output logic [7:0] ALTITUDE_OUT,
    output logic SOFT_RESET_OUT
);
    if (PWM_FULL_SCALE < 1 || PWM_FULL_SCALE > 8191) begin : g_chk
        $error("PWM_FULL_SCALE must lie in 1..8191");
    end

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_REG, ST_WR, ST_RD, ST_IGNORE
    } gsr_state_e;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic scl_s;
    logic sda_s;
    logic addr_sel_s;
    logic if_sel_s;

    gsr_pin_sync #(.RESET_LEVEL(1'b1)) u_scl (
        .clk_in(CLK_SYS_IN), .rst_n_in(RST_N_IN),
        .pin_in(SCL_IN), .level_out(scl_s));
    gsr_pin_sync #(.RESET_LEVEL(1'b1)) u_sda (
        .clk_in(CLK_SYS_IN), .rst_n_in(RST_N_IN),
        .pin_in(SDA_IN), .level_out(sda_s));
    gsr_pin_sync #(.RESET_LEVEL(1'b0)) u_adr (
        .clk_in(CLK_SYS_IN), .rst_n_in(RST_N_IN),
        .pin_in(ADDRESS_SELECT_PIN_IN), .level_out(addr_sel_s));
    gsr_pin_sync #(.RESET_LEVEL(1'b1)) u_ifs (
        .clk_in(CLK_SYS_IN), .rst_n_in(RST_N_IN),
        .pin_in(INTERFACE_SELECT_PIN_IN), .level_out(if_sel_s));

    // ----------------------------------------------------------------
    // Bus event detection
    // ----------------------------------------------------------------
    logic scl_q_r;
    logic sda_q_r;

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_q_r <= scl_s;
            sda_q_r <= sda_s;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    assign scl_rise = scl_s & ~scl_q_r;
    assign scl_fall = ~scl_s & scl_q_r;
    assign bus_start = scl_s & scl_q_r & sda_q_r & ~sda_s;
    assign bus_stop = scl_s & scl_q_r & ~sda_q_r & sda_s;

    // ----------------------------------------------------------------
    // Target state machine
    // ----------------------------------------------------------------
    gsr_state_e state_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] ptr_r;
    logic [7:0] rd_byte;
    logic oe_n_r;
    logic sda_lvl_r;
    logic receiving;
    logic byte_done;
    logic addr_hit;
    logic wr_fire;
    logic reg_fire;
    logic rd_load;

    assign receiving = (state_r == ST_ADDR) || (state_r == ST_REG) ||
                       (state_r == ST_WR);
    assign byte_done = scl_fall && receiving && (bit_cnt_r == 4'h8);
    assign addr_hit = (shift_r[7:1] == {gsr_pkg::I2C_ADDR_UPPER,
                                        addr_sel_s});  // [RULE13]
    assign wr_fire = byte_done && (state_r == ST_WR);
    assign reg_fire = byte_done && (state_r == ST_REG);
    assign rd_load = scl_fall && (state_r == ST_RD) && (bit_cnt_r == 4'h9);

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            state_r <= ST_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            oe_n_r <= 1'b1;
        end else if (if_sel_s) begin
            // Other interface selected: stay off the bus
            state_r <= ST_IDLE;  // [RULE15]
            oe_n_r <= 1'b1;
        end else if (bus_start) begin
            state_r <= ST_ADDR;
            bit_cnt_r <= 4'h0;
            oe_n_r <= 1'b1;
        end else if (bus_stop) begin
            state_r <= ST_IDLE;
            oe_n_r <= 1'b1;
        end else if (scl_rise && bit_cnt_r < 4'h8) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
            if (receiving) begin
                shift_r <= {shift_r[6:0], sda_s};  // [RULE14]
            end
        end else if (scl_rise && state_r == ST_RD && bit_cnt_r == 4'h8) begin
            // Controller NACK ends the read
            if (sda_s) begin
                state_r <= ST_IGNORE;
            end else begin
                bit_cnt_r <= 4'h9;
            end
        end else if (byte_done) begin
            bit_cnt_r <= 4'h9;
            oe_n_r <= 1'b0;
            unique case (state_r)
                ST_ADDR: begin
                    if (!addr_hit) begin
                        state_r <= ST_IGNORE;
                        oe_n_r <= 1'b1;
                    end else if (shift_r[0]) begin
                        state_r <= ST_RD;  // [RULE2]
                    end else begin
                        state_r <= ST_REG;
                    end
                end
                ST_REG: state_r <= ST_WR;
                ST_WR: state_r <= ST_WR;  // [RULE17]
                default: state_r <= ST_IGNORE;
            endcase
        end else if (scl_fall && bit_cnt_r == 4'h9) begin
            bit_cnt_r <= 4'h0;
            if (state_r == ST_RD) begin
                shift_r <= rd_byte;
                oe_n_r <= rd_byte[7];  // [RULE14]
            end else begin
                oe_n_r <= 1'b1;
            end
        end else if (scl_fall && state_r == ST_RD) begin
            if (bit_cnt_r == 4'h8) begin
                oe_n_r <= 1'b1;
            end else if (bit_cnt_r != 4'h0) begin
                shift_r <= {shift_r[6:0], 1'b0};
                oe_n_r <= shift_r[6];
            end
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            sda_lvl_r <= 1'b0;
        end else begin
            sda_lvl_r <= 1'b0;
        end
    end

    // Pointer survives STOP so a later current-address read continues
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            ptr_r <= 8'h00;
        end else if (reg_fire) begin
            ptr_r <= shift_r;
        end else if (wr_fire || rd_load) begin
            ptr_r <= ptr_r + 8'h01;  // [RULE16]
        end
    end

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    logic [7:0] mode_r;
    logic [7:0] pressure_r;
    logic [7:0] altitude_r;
    logic [7:0] alarm_hi_r;
    logic [7:0] alarm_lo_r;
    logic [7:0] pwm_comp_control_reg_r;
    logic soft_rst_r;

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            mode_r <= gsr_pkg::MODE_RESET;
            pressure_r <= gsr_pkg::PRESSURE_RESET;
            altitude_r <= gsr_pkg::ALTITUDE_RESET;
            alarm_hi_r <= gsr_pkg::ALARM_HI_RESET;  // [RULE12]
            alarm_lo_r <= gsr_pkg::ALARM_LO_RESET;  // [RULE12]
            pwm_comp_control_reg_r <= gsr_pkg::PWM_COMP_RESET;
        end else if (wr_fire) begin
            unique case (ptr_r)
                gsr_pkg::REG_MODE:
                    mode_r <= shift_r & gsr_pkg::MODE_MASK;  // [RULE1]
                gsr_pkg::REG_PRESSURE: pressure_r <= shift_r;  // [RULE9]
                gsr_pkg::REG_ALTITUDE: altitude_r <= shift_r;  // [RULE9]
                gsr_pkg::REG_ALARM_HI: alarm_hi_r <= shift_r;  // [RULE6]
                gsr_pkg::REG_ALARM_LO: alarm_lo_r <= shift_r;  // [RULE7]
                gsr_pkg::REG_PWM_COMP:
                    pwm_comp_control_reg_r <= shift_r & gsr_pkg::PWM_COMP_MASK;  // [RULE8]
                default: mode_r <= mode_r;  // [RULE17]
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            soft_rst_r <= 1'b0;
        end else begin
            soft_rst_r <= wr_fire && (ptr_r == gsr_pkg::REG_SOFT_RESET) &&
                          shift_r[gsr_pkg::RESET_TRIGGER_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Concentration and alarm
    // ----------------------------------------------------------------
    logic [14:0] conc_r;
    logic [14:0] conc_hold_r;
    logic alarm_r;
    logic [15:0] alarm_hi_ppm;
    logic [15:0] alarm_lo_ppm;

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN || soft_rst_r) begin
            conc_r <= 15'h0000;
        end else if (CONC_VALID_IN) begin
            conc_r <= (CONC_IN > gsr_pkg::CONC_MAX_PPM) ?
                      gsr_pkg::CONC_MAX_PPM : CONC_IN;  // [RULE10]
        end
    end

    // Frozen during a read so the two bytes always belong together
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            conc_hold_r <= 15'h0000;
        end else if (state_r != ST_RD) begin
            conc_hold_r <= conc_r;
        end
    end

    assign alarm_hi_ppm = {8'h00, alarm_hi_r} * gsr_pkg::THRESHOLD_STEP_PPM;
    assign alarm_lo_ppm = {8'h00, alarm_lo_r} * gsr_pkg::THRESHOLD_STEP_PPM;

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN || soft_rst_r) begin
            alarm_r <= 1'b0;
        end else if (!alarm_r && {1'b0, conc_r} >= alarm_hi_ppm) begin
            alarm_r <= 1'b1;  // [RULE6]
        end else if (alarm_r && {1'b0, conc_r} < alarm_lo_ppm) begin
            alarm_r <= 1'b0;  // [RULE7]
        end
    end

    // ----------------------------------------------------------------
    // Read data selection
    // ----------------------------------------------------------------
    always_comb begin
        rd_byte = 8'h00;
        unique case (ptr_r)
            gsr_pkg::REG_MODE: rd_byte = mode_r;
            gsr_pkg::REG_STATUS: begin
                rd_byte[gsr_pkg::STATUS_BUSY_BIT] = BUSY_IN;  // [RULE5]
                rd_byte[gsr_pkg::STATUS_ALARM_BIT] = alarm_r;
                rd_byte[gsr_pkg::STATUS_ADDR_SEL_BIT] = addr_sel_s;
                rd_byte[gsr_pkg::STATUS_IF_SEL_BIT] = if_sel_s;
            end
            gsr_pkg::REG_CONC_LO: rd_byte = conc_hold_r[7:0];  // [RULE4]
            gsr_pkg::REG_CONC_HI:
                rd_byte = {1'b0, conc_hold_r[14:8]};  // [RULE4] [RULE3]
            gsr_pkg::REG_PRESSURE: rd_byte = pressure_r;
            gsr_pkg::REG_ALTITUDE: rd_byte = altitude_r;
            gsr_pkg::REG_ALARM_HI: rd_byte = alarm_hi_r;
            gsr_pkg::REG_ALARM_LO: rd_byte = alarm_lo_r;
            gsr_pkg::REG_PWM_COMP: rd_byte = pwm_comp_control_reg_r;
            default: rd_byte = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // PWM output
    // ----------------------------------------------------------------
    localparam logic [12:0] PWM_TOP = 13'(PWM_FULL_SCALE - 1);
    // Duty stays in ppm; the compare scales it to the period length
    localparam logic [14:0] PWM_FS = 15'(gsr_pkg::PWM_FULL_SCALE_PPM);
    logic [12:0] pwm_cnt_r;
    logic [14:0] pwm_duty_r;
    logic pwm_r;

    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            pwm_cnt_r <= 13'h0000;
        end else if (pwm_cnt_r == PWM_TOP) begin
            pwm_cnt_r <= 13'h0000;
        end else begin
            pwm_cnt_r <= pwm_cnt_r + 13'h0001;
        end
    end

    // Duty only changes at period start to avoid runt pulses
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            pwm_duty_r <= 15'h0000;
        end else if (pwm_cnt_r == PWM_TOP) begin
            pwm_duty_r <= (conc_r > PWM_FS) ? PWM_FS : conc_r;  // [RULE11]
        end
    end

    // Property bit selects inverted polarity
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            pwm_r <= 1'b0;
        end else begin
            pwm_r <= pwm_comp_control_reg_r[gsr_pkg::PWM_ENABLE_BIT] &
                     ((28'(pwm_cnt_r) * 28'(PWM_FS) <
                       28'(pwm_duty_r) * 28'(PWM_FULL_SCALE)) ^
                      pwm_comp_control_reg_r[gsr_pkg::PWM_PROPERTY_BIT]);  // [RULE8]
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign SDA_OUT = sda_lvl_r;
    assign SDA_OE_N_OUT = oe_n_r;
    assign ALARM_OUT = alarm_r;
    assign PWM_OUT = pwm_r;
    assign MODE_OUT = mode_r[2:0];  // [RULE1]
    assign COMP_EN_OUT = pwm_comp_control_reg_r[gsr_pkg::COMPENSATION_ENABLE_BIT];  // [RULE9]
    assign PRESSURE_OUT = pressure_r;
    assign ALTITUDE_OUT = altitude_r;
    assign SOFT_RESET_OUT = soft_rst_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RST_N_IN);

    sequence s_mode_write;
        wr_fire && ptr_r == gsr_pkg::REG_MODE;
    endsequence
    sequence s_addr_match;
        byte_done && state_r == ST_ADDR && addr_hit;
    endsequence

    mode_write_a: assert property (s_mode_write |=>  // [RULE1]
        MODE_OUT == $past(shift_r[2:0]))
        else $error("mode register not updated");
    addr_ack_a: assert property (s_addr_match |=>  // [RULE13]
        !SDA_OE_N_OUT && (state_r == ST_RD || state_r == ST_REG))
        else $error("matching address not acknowledged");
    conc_limit_a: assert property (conc_r <= gsr_pkg::CONC_MAX_PPM)  // [RULE10]
        else $error("concentration above limit");
    pwm_sat_a: assert property (pwm_duty_r <= PWM_FS)  // [RULE11]
        else $error("PWM duty above full scale");
    alarm_set_a: assert property (!alarm_r && !soft_rst_r &&  // [RULE6]
        {1'b0, conc_r} >= alarm_hi_ppm |=> alarm_r)
        else $error("alarm not raised");
    alarm_clear_a: assert property (alarm_r && !soft_rst_r &&  // [RULE7]
        {1'b0, conc_r} < alarm_lo_ppm |=> !alarm_r)
        else $error("alarm not cleared");
    status_bits_a: assert property (  // [RULE5]
        ptr_r == gsr_pkg::REG_STATUS |->
        rd_byte == {BUSY_IN, alarm_r, 4'h0, addr_sel_s, if_sel_s})
        else $error("status layout wrong");
    iface_off_a: assert property (if_sel_s |=> SDA_OE_N_OUT &&  // [RULE15]
        state_r == ST_IDLE)
        else $error("bus driven with interface deselected");
    ptr_step_a: assert property (wr_fire || rd_load |=>  // [RULE16]
        ptr_r == $past(ptr_r) + 8'h01)
        else $error("pointer did not advance");
    ro_write_a: assert property (wr_fire &&  // [RULE17]
        (ptr_r == gsr_pkg::REG_STATUS || ptr_r == gsr_pkg::REG_CONC_LO)
        |=> $stable(pwm_comp_control_reg_r) && $stable(alarm_hi_r) && $stable(mode_r))
        else $error("read-only write changed state");
    msb_first_a: assert property (rd_load && !if_sel_s &&  // [RULE14]
        !bus_start && !bus_stop |=> SDA_OE_N_OUT == $past(rd_byte[7]))
        else $error("read byte not MSB first");
endmodule : gsr_top
`default_nettype wire

// file: verification/gsr_host.sv
/* I2C host model: drives SCL, pulls SDA low or releases it.
   Assumes the bench resolves SDA with a pull-up. */
`timescale 1ns/1ps
`default_nettype none
module gsr_host (
    input wire logic clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    // ------------------------------------------------------------
    // Bus phases, ten system clocks each
    // ------------------------------------------------------------
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    task automatic hw();
        repeat (10) @(posedge clk_in);
    endtask : hw
    // Also a repeated start when SCL is low
    task automatic start();
        sda_low_out <= 1'b0;
        hw();
        scl_out <= 1'b1;
        hw();
        sda_low_out <= 1'b1;
        hw();
        scl_out <= 1'b0;
        hw();
    endtask : start
    task automatic stop();
        sda_low_out <= 1'b1;
        hw();
        scl_out <= 1'b1;
        hw();
        sda_low_out <= 1'b0;
        hw();
    endtask : stop
    // SDA only moves while SCL is low, so no false start or stop
    task automatic bit_io(input logic b, output logic s);
        sda_low_out <= ~b;
        hw();
        scl_out <= 1'b1;
        hw();
        s = sda_in;
        scl_out <= 1'b0;
        hw();
    endtask : bit_io
    task automatic xfer(input logic [7:0] d, input logic ak,
                        output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(ak, a);
    endtask : xfer
endmodule : gsr_host
`default_nettype wire

// file: verification/tb.sv
/* Self-checking bench of the sensor register interface.
   Assumes gsr_host as bus master and a pulled-up SDA wire. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic asel = 1'b0;
    logic isel = 1'b0;
    logic [14:0] cv = 15'h0000;
    logic vld = 1'b0;
    logic busy = 1'b0;
    logic scl, hlow, oe_n, sdo, sda, alarm, pwm, comp, srst;
    logic [2:0] mode;
    logic [7:0] pres, alt, wa, a, b;
    int mismatches = 0;
    int cmp_count = 0;
    int npulse = 0;
    always #25 clk = ~clk;
    assign sda = ~hlow & (oe_n | sdo);
    assign wa = {gsr_pkg::I2C_ADDR_UPPER, asel, 1'b0};
    always @(negedge clk) npulse += int'(srst === 1'b1);
    gsr_top #(.PWM_FULL_SCALE(50)) DUT (.CLK_SYS_IN(clk),
        .RST_N_IN(rst_n), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sdo),
        .SDA_OE_N_OUT(oe_n), .ADDRESS_SELECT_PIN_IN(asel),
        .INTERFACE_SELECT_PIN_IN(isel), .CONC_IN(cv),
        .CONC_VALID_IN(vld), .BUSY_IN(busy), .ALARM_OUT(alarm),
        .PWM_OUT(pwm), .MODE_OUT(mode), .COMP_EN_OUT(comp),
        .PRESSURE_OUT(pres), .ALTITUDE_OUT(alt), .SOFT_RESET_OUT(srst));
    gsr_host host (.clk_in(clk), .sda_in(sda), .scl_out(scl),
        .sda_low_out(hlow));
    // ------------------------------------------------------------
    // Shared steps
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [7:0] e, s);
        cmp_count++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic tx(input logic [7:0] d, input logic ea);
        logic [7:0] q;
        logic k;
        host.xfer(d, 1'b1, q, k);
        chk("ack", 8'(ea), 8'(k));
    endtask : tx
    task automatic wr(input logic [7:0] r, d);
        host.start();
        tx(wa, 1'b0);
        tx(r, 1'b0);
        tx(d, 1'b0);
        host.stop();
    endtask : wr
    task automatic rd(input logic [7:0] r);
        logic k;
        host.start();
        tx(wa, 1'b0);
        tx(r, 1'b0);
        host.start();
        tx(wa | 8'h01, 1'b0);
        host.xfer(8'hFF, 1'b0, a, k);
        host.xfer(8'hFF, 1'b1, b, k);
        host.stop();
    endtask : rd
    task automatic conc(input logic [14:0] v, input logic e);
        cv <= v;
        vld <= 1'b1;
        cyc(1);
        vld <= 1'b0;
        cyc(3);
        chk("alarm", 8'(e), 8'(alarm));
    endtask : conc
    task automatic pwm_chk(input logic [7:0] e);
        logic [7:0] n;
        n = 8'h00;
        cyc(110);
        repeat (50) begin
            @(negedge clk);
            n += 8'(pwm);
        end
        @(posedge clk);
        chk("pwm_high", e, n);
    endtask : pwm_chk
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rd(8'h0C);
        chk("alarm_hi", 8'h64, a);
        chk("alarm_lo", 8'h5A, b);
        wr(8'h01, 8'h06);
        chk("mode_out", 8'h06, 8'(mode));
        rd(8'h01);
        chk("mode_rd", 8'h06, a);
        chk("status", 8'h00, b);
        $display("test regs done");
    endtask : t_regs
    task automatic t_conc();
        conc(15'h1234, 1'b1);
        wr(8'h03, 8'hFF);
        rd(8'h03);
        chk("conc_lo", 8'h34, a);
        chk("conc_hi", 8'h12, b);
        conc(15'h7FFF, 1'b1);
        rd(8'h03);
        chk("clamp_lo", 8'h10, a);
        chk("clamp_hi", 8'h27, b);
        conc(15'h0383, 1'b0);
        conc(15'h03E7, 1'b0);
        conc(15'h03E8, 1'b1);
        conc(15'h0384, 1'b1);
        busy <= 1'b1;
        asel <= 1'b1;
        cyc(6);
        rd(8'h02);
        chk("status", 8'hC2, a);
        chk("conc_lo", 8'h84, b);
        busy <= 1'b0;
        asel <= 1'b0;
        conc(15'h0383, 1'b0);
        $display("test conc done");
    endtask : t_conc
    task automatic t_refuse();
        host.start();
        tx(8'hD2, 1'b1);
        host.stop();
        isel <= 1'b1;
        cyc(6);
        host.start();
        tx(wa, 1'b1);
        host.stop();
        isel <= 1'b0;
        cyc(6);
        $display("test refuse done");
    endtask : t_refuse
    task automatic t_pwm();
        wr(8'h0F, 8'hFF);
        rd(8'h0F);
        chk("pwm_comp_control_reg", 8'h0D, a);
        chk("comp_en", 8'h01, 8'(comp));
        host.start();
        tx(wa, 1'b0);
        tx(8'h09, 1'b0);
        tx(8'hA5, 1'b0);
        tx(8'h3C, 1'b0);
        host.stop();
        chk("pressure", 8'hA5, pres);
        chk("altitude", 8'h3C, alt);
        wr(8'h0F, 8'h01);
        conc(15'h03E8, 1'b1);
        pwm_chk(8'd10);
        conc(15'h1F40, 1'b1);
        pwm_chk(8'd50);
        wr(8'h0F, 8'h09);
        pwm_chk(8'd0);
        wr(8'h0F, 8'h00);
        pwm_chk(8'd0);
        $display("test pwm done");
    endtask : t_pwm
    task automatic t_reset_cur();
        logic k;
        wr(8'h00, 8'h00);
        chk("soft_rst", 8'd0, 8'(npulse));
        wr(8'h00, 8'h01);
        chk("soft_rst", 8'd1, 8'(npulse));
        host.start();
        tx(wa, 1'b0);
        tx(8'h03, 1'b0);
        host.stop();
        host.start();
        tx(wa | 8'h01, 1'b0);
        host.xfer(8'hFF, 1'b1, a, k);
        host.stop();
        chk("cur_read", 8'h00, a);
        chk("mode_kept", 8'h06, 8'(mode));
        $display("test reset and current read done");
    endtask : t_reset_cur
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize
    initial begin
        cyc(20);
        rst_n <= 1'b1;
        cyc(6);
        t_regs();
        t_conc();
        t_refuse();
        t_pwm();
        t_reset_cur();
        summarize();
    end
    // Watchdog well past the expected run of about 20000 cycles
    initial begin
        cyc(95000);
        mismatches++;
        summarize();
    end
endmodule : tb
`default_nettype wire
